/* File: rtl/io_ports_consts.vh */
// Register offsets, reset values and field positions of the I/O ports
`ifndef IO_PORTS_CONSTS_VH
`define IO_PORTS_CONSTS_VH
`define OFS_FIRST_DATA 8'h05
`define OFS_SECOND_DATA 8'h06
`define OFS_OPTION 8'h81
`define OFS_FIRST_DIR 8'h85
`define OFS_SECOND_DIR 8'h86
`define OFS_ANALOG_CFG 8'h9F
`define OFS_FIRST_SET 8'hA0
`define OFS_FIRST_CLR 8'hA1
`define OFS_SECOND_SET 8'hA2
`define OFS_SECOND_CLR 8'hA3
`define OFS_IRQ_STATUS 8'hA4
`define OFS_IRQ_MASK 8'hA5
`define RST_OPTION 8'hFF
`define RST_FIRST_DIR 6'h3F
`define RST_SECOND_DIR 8'hFF
`define RST_ANALOG_CFG 3'h0
`define RST_IRQ 2'h0
`define OPT_PULLUP_BIT 7
`define OPT_EDGE_BIT 6
`define IRQ_EXT_BIT 0
`define IRQ_CHANGE_BIT 1
`define TIMER_CLK_BIT 4
`define SERIAL_SEL_BIT 5
`endif

/* File: rtl/dual_io_ports.v */
// Two general-purpose I/O ports with alternate pin functions
// Operation
// R1: Six-bit first port, direction one means input
// R2: Data read returns pins, write loads latch
// R3: Port writes merge sampled pins into latch
// R4: Enabled peripheral takes over its shared pin
// R5: First port bit 4 timer clock, open-drain
// R6: First port bit 5 serial select input
// R7: Three config bits pick analog or digital
// R8: Analog pins after reset, digital read zero
// R9: Software keeps direction set on analog pins
// R10: Software keeps config zero without converter
// R11: First direction resets to all ones
// R12: First data reset: bit5 kept, 3:0 cleared
// R13: Second direction all ones, latch kept
// R14: Second port weak pull-ups under option bit7
// R15: Second port bits 7:4 interrupt on change
// R16: Second port bit 0 external interrupt input
// R17: Bits 6 and 7 serial programming clock, data
// R18: Pull-up off while pin is an output
`include "io_ports_consts.vh"
module dual_io_ports
#(
    parameter HAS_ANALOG = 1
)
(
    input wire mclk_in,
    input wire rst_in,
    input wire por_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [5:0] first_pins_in,
    output wire [5:0] first_pins_out,
    output wire [5:0] first_pins_oe_out,
    input wire [7:0] second_pins_in,
    output wire [7:0] second_pins_out,
    output wire [7:0] second_pins_oe_out,
    output wire [7:0] pullup_en_out,
    input wire serial_select_en_in,
    output wire serial_select_out,
    output wire timer_clock_out,
    output wire [5:0] analog_sel_out,
    input wire prog_mode_in,
    output wire prog_clock_out,
    output wire prog_data_out,
    output wire irq_out
);
    wire [5:0] first_sync_q;
    wire [7:0] second_sync_q;
    reg [7:0] second_prev_q;
    reg [3:0] first_low_q;
    reg [1:0] first_high_q;
    reg [7:0] second_latch_q;
    reg [5:0] first_dir_q;
    reg [7:0] second_dir_q;
    reg [7:0] option_q;
    reg [2:0] analog_cfg_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;
    reg [5:0] analog_mask;
    reg [5:0] first_latch_d;
    reg [7:0] second_latch_d;
    reg [1:0] irq_status_d;
    reg [7:0] rdata_d;
    wire [5:0] first_latch;
    wire [5:0] first_read;
    wire [5:0] first_drive;
    wire [7:0] second_drive;
    wire ext_edge;
    wire change_hit;
    wire [1:0] irq_events;

    assign first_latch = {first_high_q, first_low_q};

    // Pins come from outside the clock domain
    pin_sync
    #(
        .WIDTH(6)
    )
    i_first_sync
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .pins_in(first_pins_in),
        .sync_out(first_sync_q)
    );

    // Second port pins, same two stages
    pin_sync
    #(
        .WIDTH(8)
    )
    i_second_sync
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .pins_in(second_pins_in),
        .sync_out(second_sync_q)
    );

    // Previous synced level for edge and change detection
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            second_prev_q <= 8'h00;
        else
            second_prev_q <= second_sync_q;
    end

    // Digital role per pin; reset config makes analog pins analog
    always @*
    begin
        analog_mask = 6'h00;
        if (HAS_ANALOG != 0)
        begin
            case (analog_cfg_q) // R7 R8
                3'h0: analog_mask = 6'h2F;
                3'h1: analog_mask = 6'h2F;
                3'h2: analog_mask = 6'h2F;
                3'h3: analog_mask = 6'h2B;
                3'h4: analog_mask = 6'h0B;
                3'h5: analog_mask = 6'h03;
                3'h6: analog_mask = 6'h00;
                3'h7: analog_mask = 6'h00;
                default: analog_mask = 6'h00;
            endcase
        end
    end
    assign analog_sel_out = analog_mask;

    // Analog pins read zero on data reads and set/clear merges; serial select still sees the pin
    assign first_read = first_sync_q & ~analog_mask; // R2 R8

    // Driver enable: direction zero drives the latch
    assign first_drive = ~first_dir_q; // R1
    assign first_pins_out = {first_latch[5], 1'b0, first_latch[3:0]};
    // Bit 4 only ever pulls low
    assign first_pins_oe_out[3:0] = first_drive[3:0]; // R1
    assign first_pins_oe_out[`TIMER_CLK_BIT] =
        first_drive[`TIMER_CLK_BIT] & ~first_latch[`TIMER_CLK_BIT]; // R5
    // Select pin belongs to the serial unit while enabled
    assign first_pins_oe_out[`SERIAL_SEL_BIT] =
        first_drive[`SERIAL_SEL_BIT] & ~serial_select_en_in; // R4 R6
    assign serial_select_out =
        serial_select_en_in & first_sync_q[`SERIAL_SEL_BIT]; // R6
    assign timer_clock_out = first_sync_q[`TIMER_CLK_BIT]; // R5

    // Programming mode takes bits 6 and 7 away from the port
    assign second_drive = prog_mode_in ?
        (~second_dir_q & 8'h3F) : ~second_dir_q; // R4 R17
    assign second_pins_out = second_latch_q;
    assign second_pins_oe_out = second_drive;
    assign prog_clock_out = prog_mode_in & second_sync_q[6]; // R17
    assign prog_data_out = prog_mode_in & second_sync_q[7]; // R17

    // Pull-up bit is active low; outputs never pull up
    assign pullup_en_out = {8{~option_q[`OPT_PULLUP_BIT]}}
        & second_dir_q; // R14 R18

    // Edge polarity chosen by option bit 6
    assign ext_edge = option_q[`OPT_EDGE_BIT] ?
        (second_sync_q[0] & ~second_prev_q[0]) :
        (~second_sync_q[0] & second_prev_q[0]); // R16
    // Only input pins report a change
    assign change_hit = |((second_sync_q[7:4] ^ second_prev_q[7:4])
        & second_dir_q[7:4]); // R15
    assign irq_events[`IRQ_EXT_BIT] = ext_edge; // R16
    assign irq_events[`IRQ_CHANGE_BIT] = change_hit; // R15

    // Next latch values; set and clear writes start from sampled pins, data writes load wdata_in
    always @*
    begin
        first_latch_d = first_latch;
        second_latch_d = second_latch_q;
        if (wr_in)
        begin
            case (addr_in)
                `OFS_FIRST_DATA: first_latch_d = wdata_in[5:0]; // R2
                `OFS_SECOND_DATA: second_latch_d = wdata_in; // R2
                `OFS_FIRST_SET:
                    first_latch_d = first_read | wdata_in[5:0]; // R3
                `OFS_FIRST_CLR:
                    first_latch_d = first_read & ~wdata_in[5:0]; // R3
                `OFS_SECOND_SET:
                    second_latch_d = second_sync_q | wdata_in; // R3
                `OFS_SECOND_CLR:
                    second_latch_d = second_sync_q & ~wdata_in; // R3
                default:
                begin
                    first_latch_d = first_latch;
                    second_latch_d = second_latch_q;
                end
            endcase
        end
    end

    // Low latch bits clear on any reset
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            first_low_q <= 4'h0; // R12
        else if (por_in)
            first_low_q <= 4'h0;
        else
            first_low_q <= first_latch_d[3:0];
    end

    // Kept across warm reset; only power-on clears them
    always @(posedge mclk_in)
    begin
        if (por_in)
            first_high_q <= 2'h0; // R12
        else if (!rst_in)
            first_high_q <= first_latch_d[5:4];
    end

    // Second latch survives warm reset
    always @(posedge mclk_in)
    begin
        if (por_in)
            second_latch_q <= 8'h00; // R13
        else if (!rst_in)
            second_latch_q <= second_latch_d;
    end

    // Set wins over a write-one clear in the same cycle
    always @*
    begin
        irq_status_d = irq_status_q;
        if (wr_in && addr_in == `OFS_IRQ_STATUS)
            irq_status_d = irq_status_q & ~wdata_in[1:0];
        irq_status_d = irq_status_d | irq_events;
    end

    // Directions reset to inputs on rst_in, not on por_in alone
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            first_dir_q <= `RST_FIRST_DIR; // R11
            second_dir_q <= `RST_SECOND_DIR; // R13
        end
        else if (wr_in)
        begin
            if (addr_in == `OFS_FIRST_DIR)
                first_dir_q <= wdata_in[5:0]; // R1
            if (addr_in == `OFS_SECOND_DIR)
                second_dir_q <= wdata_in;
        end
    end

    // Option register
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            option_q <= `RST_OPTION;
        else if (wr_in && addr_in == `OFS_OPTION)
            option_q <= wdata_in; // R14
    end

    // Reset config leaves analog pins analog
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            analog_cfg_q <= `RST_ANALOG_CFG; // R8
        else if (wr_in && addr_in == `OFS_ANALOG_CFG)
            analog_cfg_q <= wdata_in[2:0]; // R7
    end

    // Status flags
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            irq_status_q <= `RST_IRQ;
        else
            irq_status_q <= irq_status_d;
    end

    // Interrupt mask
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            irq_mask_q <= `RST_IRQ;
        else if (wr_in && addr_in == `OFS_IRQ_MASK)
            irq_mask_q <= wdata_in[1:0];
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        rdata_d = 8'h00;
        case (addr_in)
            `OFS_FIRST_DATA: rdata_d = {2'h0, first_read}; // R2
            `OFS_SECOND_DATA: rdata_d = second_sync_q; // R2
            `OFS_OPTION: rdata_d = option_q;
            `OFS_FIRST_DIR: rdata_d = {2'h0, first_dir_q};
            `OFS_SECOND_DIR: rdata_d = second_dir_q;
            `OFS_ANALOG_CFG: rdata_d = {5'h00, analog_cfg_q};
            `OFS_IRQ_STATUS: rdata_d = {6'h00, irq_status_q};
            `OFS_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rdata_d;
        else
            rdata_out <= 8'h00;
    end

    assign irq_out = |(irq_status_q & irq_mask_q);
endmodule // dual_io_ports

// Two-stage synchroniser for pins
module pin_sync
#(
    parameter WIDTH = 8
)
(
    input wire mclk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] pins_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    // Only the second stage is read by logic
    always @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= pins_in;
            sync_out <= meta_q;
        end
    end
endmodule // pin_sync

/* File: verification/io_ports_props.sv */
// Port assertions of the dual I/O ports
`include "io_ports_consts.vh"
module io_ports_props
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [5:0] first_pins_out,
    input wire logic [5:0] first_pins_oe_out,
    input wire logic [7:0] second_pins_out,
    input wire logic [7:0] second_pins_oe_out,
    input wire logic [7:0] pullup_en_out,
    input wire logic [5:0] analog_sel_out,
    input wire logic irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_read_slot_only: assert property (!$past(rd_in) |-> rdata_out == 0)
        else $error("read data outside slot");
    a_mask_gates_irq: assert property (wr_in && addr_in == `OFS_IRQ_MASK
        && wdata_in == 0 |=> !irq_out) else $error("masked irq high");
    a_first_dir_oe: assert property (wr_in && addr_in == `OFS_FIRST_DIR
        |=> (first_pins_oe_out[3:0] ^ 4'($past(wdata_in))) == 4'hF)
        else $error("first oe mismatch");
    a_second_dir_oe: assert property (wr_in && addr_in == `OFS_SECOND_DIR
        |=> (second_pins_oe_out[5:0] ^ 6'($past(wdata_in))) == 6'h3F)
        else $error("second oe mismatch");
    a_second_latch: assert property (wr_in && addr_in == `OFS_SECOND_DATA
        |=> second_pins_out == $past(wdata_in)) else $error("latch");
    a_reset_inputs: assert property ($fell(rst_in) |->
        first_pins_oe_out == 0 && second_pins_oe_out == 0
        && pullup_en_out == 0) else $error("pins not inputs");
    a_analog_reads_zero: assert property (rd_in &&
        addr_in == `OFS_FIRST_DATA |=> (rdata_out[5:0]
        & $past(analog_sel_out)) == 0) else $error("analog bit read");
    a_bit4_open_drain: assert property (!first_pins_out[4])
        else $error("bit4 driven high");
    a_pullup_output: assert property (!(pullup_en_out
        & second_pins_oe_out)) else $error("pull-up on output");
    c_irq: cover property ($rose(irq_out));
    c_analog: cover property (rd_in && analog_sel_out != 0);
    c_warm: cover property ($fell(rst_in));
endmodule // io_ports_props
bind dual_io_ports io_ports_props i_props
(
    .mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .first_pins_out, .first_pins_oe_out,
    .second_pins_out, .second_pins_oe_out, .pullup_en_out,
    .analog_sel_out, .irq_out
);

/* File: verification/pin_board.sv */
// Pins and board parts outside the ports
module pin_board
(
    input wire logic mclk_in,
    input wire logic [13:0] oe_in,
    input wire logic [13:0] drv_in,
    input wire logic [13:0] pull_in,
    input wire logic [13:0] ext_en_in,
    input wire logic [13:0] ext_in,
    output logic [13:0] pins_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] float_q = 14'h0000;
    // Undriven pins without pull-up toggle, never hold a stale level
    always @(posedge mclk_in)
        float_q <= ~float_q;
    // Drivers win, then board parts, then weak pull-ups
    assign pins_out = (oe_in & drv_in)
        | (~oe_in & ext_en_in & ext_in)
        | (~oe_in & ~ext_en_in & (pull_in | float_q));
endmodule // pin_board

/* File: verification/test_dual_bidirectional_io_ports.sv */
// Self-checking bench of the dual I/O ports
`include "io_ports_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("Error %s exp %h got %h", n, e, g); end end
module test_dual_bidirectional_io_ports;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic por_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sel_en = 1'b0;
    logic prog = 1'b0;
    logic [13:0] ext_en = 14'h3FFF;
    logic [13:0] ext = 14'h3FFF;
    logic [13:0] pins;
    logic [7:0] rdata_out, second_pins_out, second_pins_oe_out, pull_en;
    logic [5:0] first_pins_out, first_pins_oe_out, analog_sel_out;
    logic sel_out, tclk, pclk, pdat, irq_out;
    logic [7:0] d, v, p, w;
    int failures = 0;
    int tests_run = 0;
    int amap[8] = '{8'h2F, 8'h2F, 8'h2F, 8'h2B, 8'h0B, 8'h03, 0, 0};
    int rtab[$] = '{`OFS_OPTION, 8'hFF, `OFS_FIRST_DIR, 8'h3F,
        `OFS_SECOND_DIR, 8'hFF, `OFS_ANALOG_CFG, 0, `OFS_IRQ_MASK, 0, 8'h10, 0};
    always #5 mclk_in = ~mclk_in;
    dual_io_ports i_dut (.mclk_in, .rst_in, .por_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .first_pins_in(pins[5:0]),
        .first_pins_out, .first_pins_oe_out, .second_pins_in(pins[13:6]),
        .second_pins_out, .second_pins_oe_out, .pullup_en_out(pull_en),
        .serial_select_en_in(sel_en), .serial_select_out(sel_out),
        .timer_clock_out(tclk), .analog_sel_out, .prog_mode_in(prog),
        .prog_clock_out(pclk), .prog_data_out(pdat), .irq_out);
    pin_board i_board (.mclk_in, .ext_en_in(ext_en), .ext_in(ext),
        .oe_in({second_pins_oe_out, first_pins_oe_out}),
        .drv_in({second_pins_out, first_pins_out}),
        .pull_in({pull_en, 6'h00}), .pins_out(pins));
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= x;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        `CHK("rdata_out", e, rdata_out)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        failures++;
        complete_run();
    end
    initial
    begin
        void'($urandom(18853));
        tick(2);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        for (int i = 0; i < rtab.size(); i += 2)
            rdc(rtab[i], rtab[i + 1]);
        for (int c = 0; c < 8; c++)
        begin
            wr(`OFS_ANALOG_CFG, c);
            rdc(`OFS_FIRST_DATA, 8'h3F & ~amap[c]);
        end
        v = $urandom;
        wr(`OFS_FIRST_DATA, v);
        ext_en <= 14'h3FD0;
        wr(`OFS_FIRST_DIR, 8'h00);
        tick(3);
        rdc(`OFS_FIRST_DATA, v & 8'h3F);
        `CHK("timer_clock_out", v[4], tclk)
        sel_en <= 1'b1;
        ext_en <= 14'h3FF0;
        tick(4);
        #1;
        `CHK("first_pins_oe_out", 1'b0, first_pins_oe_out[5])
        `CHK("serial_select_out", 1'b1, sel_out)
        sel_en <= 1'b0;
        p = $urandom;
        w = $urandom;
        ext <= {8'hFF, p[5:0]};
        wr(`OFS_FIRST_DIR, 8'h3F);
        ext_en <= 14'h3FFF;
        tick(3);
        wr(`OFS_FIRST_SET, w);
        ext <= 14'h3FFF;
        ext_en <= 14'h3FD0;
        wr(`OFS_FIRST_DIR, 8'h00);
        tick(3);
        rdc(`OFS_FIRST_DATA, (p | w) & 8'h3F);
        v = (p | w) & ~w & 8'h3F;
        wr(`OFS_FIRST_CLR, w);
        d = $urandom;
        w = $urandom;
        ext_en <= 14'h0010;
        wr(`OFS_OPTION, 8'h7F);
        wr(`OFS_SECOND_DATA, w);
        wr(`OFS_SECOND_DIR, d);
        tick(3);
        rdc(`OFS_SECOND_DATA, w & ~d | d);
        `CHK("pullup_en_out", d, pull_en)
        rst_in <= 1'b1;
        tick(2);
        rst_in <= 1'b0;
        #1;
        `CHK("second_pins_out", w, second_pins_out)
        `CHK("first latch", {v[5], 5'h00}, first_pins_out & 6'h2F)
        ext <= 14'h0000;
        ext_en <= 14'h3FFF;
        wr(`OFS_OPTION, 8'h40);
        tick(4);
        wr(`OFS_IRQ_STATUS, 8'hFF);
        wr(`OFS_IRQ_MASK, 8'h03);
        ext[6] <= 1'b1;
        tick(4);
        #1;
        `CHK("irq_out", 1'b1, irq_out)
        rdc(`OFS_IRQ_STATUS, 8'h01);
        wr(`OFS_IRQ_STATUS, 8'h01);
        `CHK("irq_out", 1'b0, irq_out)
        ext[12] <= 1'b1;
        tick(4);
        rdc(`OFS_IRQ_STATUS, 8'h02);
        wr(`OFS_IRQ_MASK, 8'h00);
        `CHK("irq_out", 1'b0, irq_out)
        prog <= 1'b1;
        tick(4);
        #1;
        `CHK("prog pins", 2'b01, {pdat, pclk})
        complete_run();
    end
endmodule // test_dual_bidirectional_io_ports
